// ### dmr_defs.svh
// dmr_defs.svh: offsets, field positions, codes and limits of the drive monitor register bank
// assumes: included by dmr_register_map.sv by bare name
`ifndef DMR_DEFS_SVH
`define DMR_DEFS_SVH

// register offsets
`define DMR_A_AO2        16'h200E
`define DMR_A_STATE      16'h2100
`define DMR_A_FLAGS      16'h2101
`define DMR_A_FAULT      16'h2102
`define DMR_A_FREQ_ACT   16'h3000
`define DMR_A_FREQ_SET   16'h3001
`define DMR_A_VBUS       16'h3002
`define DMR_A_VOUT       16'h3003
`define DMR_A_IOUT       16'h3004
`define DMR_A_SPEED      16'h3005
`define DMR_A_POWER      16'h3006
`define DMR_A_TORQUE     16'h3007
`define DMR_A_LOOP_REF   16'h3008
`define DMR_A_LOOP_FB    16'h3009
`define DMR_A_IN_MASK    16'h300A
`define DMR_A_OUT_MASK   16'h300B
`define DMR_A_AIN1       16'h300C
`define DMR_A_AIN2       16'h300D
`define DMR_A_AIN3       16'h300E
`define DMR_A_AIN4       16'h300F
`define DMR_A_PULSE1     16'h3010
`define DMR_A_PULSE2     16'h3011
`define DMR_A_STEP       16'h3012
`define DMR_A_LENGTH     16'h3013
`define DMR_A_COUNT      16'h3014
`define DMR_A_TQ_REF     16'h3015
`define DMR_A_IDENT      16'h3016
`define DMR_A_FAULT_REC  16'h5000

// second status word field positions
`define DMR_F_READY      0
`define DMR_F_MOTOR      1
`define DMR_F_SYNC       3
`define DMR_F_OVL        4
`define DMR_F_SRC        5
`define DMR_F_TORQUE     8
`define DMR_F_POS        9
`define DMR_F_METHOD     10

// function and exception codes
`define DMR_FC_READ      8'h03
`define DMR_FC_WRITE     8'h06
`define DMR_FC_EXC       8'h80
`define DMR_EC_FUNC      8'h01
`define DMR_EC_ADDR      8'h02
`define DMR_EC_VALUE     8'h04
`define DMR_EC_RO        8'h07

// scaling, limits and reset values
`define DMR_AO_FS        1000
`define DMR_SCALE_1DP    10
`define DMR_VBUS_MAX     16'h4E20
`define DMR_STEP_MAX     16'h000F
`define DMR_AO2_RST      16'h0000
`define DMR_IDENT_RST    16'h0A5A

`endif

// ### dmr_master_model.sv
// dmr_master_model.sv: fieldbus master issuing single register requests
// assumes: bank registers its answer on the taking mclk edge, sampled 1 ns later
`timescale 1ns/100ps
`default_nettype none
module dmr_master_model (
	// clock
	input  wire logic       mclk,
	// request to bank
	output var logic        req_valid,
	output var logic [7:0]  req_func,
	output var logic [15:0] req_addr,
	output var logic [15:0] req_wdata,
	// response from bank
	input  wire logic       rsp_valid_ff
);
	initial begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
	end
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, d, output logic ok);
		@(posedge mclk);
		req_valid <= 1'b1;
		req_func <= f;
		req_addr <= a;
		req_wdata <= d;
		@(posedge mclk);
		req_valid <= 1'b0;
		req_func <= ~f;
		req_addr <= ~a;
		req_wdata <= ~d;
		#1 ok = (rsp_valid_ff === 1'b1);
	endtask
endmodule
`default_nettype wire

// ### dmr_pkg.sv
// dmr_pkg.sv: types shared by the drive monitor register bank
// assumes: enum codes are written out here, not taken from dmr_defs.svh
`default_nettype none
package dmr_pkg;
	// drive run state reported in the first status word
	typedef enum logic [2:0] {
		DMR_RUN_FWD   = 3'h1,
		DMR_RUN_REV   = 3'h2,
		DMR_STOPPED   = 3'h3,
		DMR_FAULTY    = 3'h4,
		DMR_POWER_OFF = 3'h5,
		DMR_PRE_EXC   = 3'h6
	} dmr_run_state_t;

	// command source field of the second status word
	typedef enum logic [1:0] {
		DMR_SRC_KEYPAD   = 2'h0,
		DMR_SRC_TERMINAL = 2'h1,
		DMR_SRC_COMM     = 2'h2
	} dmr_cmd_src_t;
endpackage
`default_nettype wire

// ### dmr_register_map.sv
// dmr_register_map.sv: register bank behind the drive's fieldbus slave
// assumes: a frame decoder on mclk presents one register request per req_valid pulse,
// drive core values arrive on mclk, input terminals arrive straight from pins
`include "dmr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module dmr_register_map #(
	parameter int          AO_FULL_SCALE = `DMR_AO_FS,
	parameter int          AO_SCALE      = `DMR_SCALE_1DP,
	// identity value is arbitrary
	parameter logic [15:0] IDENT_CODE    = `DMR_IDENT_RST
) (
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    reset,
	// register request from frame decoder
	input  wire logic                    req_valid,
	input  wire logic [7:0]              req_func,
	input  wire logic [15:0]             req_addr,
	input  wire logic [15:0]             req_wdata,
	// register response to frame encoder
	output logic                         rsp_valid_ff,
	output logic [7:0]                   rsp_func_ff,
	output logic [15:0]                  rsp_data_ff,
	output logic                         rsp_exc_ff,
	output logic [7:0]                   rsp_code_ff,
	// drive state
	input  wire dmr_pkg::dmr_run_state_t run_state,
	input  wire logic                    drive_ready,
	input  wire logic [1:0]              motor_select,
	input  wire logic                    sync_machine,
	input  wire logic                    overload_alarm,
	input  wire dmr_pkg::dmr_cmd_src_t   cmd_source,
	input  wire logic                    torque_mode,
	input  wire logic                    position_mode,
	input  wire logic [1:0]              control_method,
	input  wire logic [15:0]             fault_number,
	input  wire logic [15:0]             fault_history,
	// monitored values, scaled integers
	input  wire logic [15:0]             freq_actual,
	input  wire logic [15:0]             freq_target,
	input  wire logic [15:0]             dc_link_volts,
	input  wire logic [15:0]             motor_volts,
	input  wire logic [15:0]             motor_amps,
	input  wire logic [15:0]             shaft_rpm,
	input  wire logic signed [15:0]      power_pct,
	input  wire logic signed [15:0]      torque_pct,
	input  wire logic signed [15:0]      loop_ref_pct,
	input  wire logic signed [15:0]      loop_meas_pct,
	input  wire logic [15:0]             ain_one,
	input  wire logic [15:0]             ain_two,
	input  wire logic signed [15:0]      ain_three,
	input  wire logic signed [15:0]      ain_four,
	input  wire logic [15:0]             pulse_a_rate,
	input  wire logic [15:0]             pulse_b_rate,
	input  wire logic [3:0]              speed_step,
	input  wire logic [15:0]             length_count,
	input  wire logic [15:0]             event_count,
	input  wire logic signed [15:0]      torque_ref_pct,
	// terminals
	input  wire logic [5:0]              input_terminal_pins,
	input  wire logic [3:0]              output_terminal_state,
	// analog output source selection
	input  wire logic                    ao_two_src_comm,
	// analog output two, stored setpoint and applied setting
	output logic signed [15:0]           ao_two_setpoint_ff,
	output logic signed [7:0]            ao_two_pct_ff
);

	generate
		if (AO_FULL_SCALE <= 0 || AO_FULL_SCALE > 32767) begin : g_bad_fs
			$error("dmr_register_map: analog output full scale out of range");
		end
		if (AO_SCALE <= 0) begin : g_bad_scale
			$error("dmr_register_map: analog output scale must be positive");
		end else if (AO_FULL_SCALE / AO_SCALE > 127) begin : g_bad_pct
			$error("dmr_register_map: applied output exceeds eight bits");
		end
	endgenerate

	localparam logic signed [15:0] AO_MAX = 16'(AO_FULL_SCALE);
	localparam logic signed [15:0] AO_MIN = -16'(AO_FULL_SCALE);
	localparam logic signed [15:0] AO_DIV = 16'(AO_SCALE);

	// terminal pin synchronisers
	logic [5:0]  term_s1_ff;
	logic [5:0]  term_s2_ff;
	logic [5:0]  term_s3_ff;
	logic [5:0]  term_state_ff;

	// decode results
	logic [15:0] flags_word;
	logic [15:0] vbus_clamped;
	logic [15:0] step_clamped;
	logic [15:0] rd_data;
	logic        rd_hit;
	logic        wr_ok;
	logic        wr_range_ok;
	logic        is_read;
	logic        is_write;
	logic [7:0]  nxt_code;
	logic        nxt_exc;
	logic [15:0] nxt_data;
	logic signed [15:0] nxt_ao_setpoint;
	logic signed [7:0]  nxt_ao_pct;

	// three-stage sync, change taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_term
			always_ff @(posedge mclk) begin
				if (reset) begin
					term_s1_ff[gi]    <= 1'b0;
					term_s2_ff[gi]    <= 1'b0;
					term_s3_ff[gi]    <= 1'b0;
					term_state_ff[gi] <= 1'b0;
				end else begin
					term_s1_ff[gi] <= input_terminal_pins[gi];
					term_s2_ff[gi] <= term_s1_ff[gi];
					term_s3_ff[gi] <= term_s2_ff[gi];
					if (term_s2_ff[gi] == term_s3_ff[gi]) begin
						term_state_ff[gi] <= term_s3_ff[gi];
					end
				end
			end
		end
	endgenerate

	// second status word assembly
	always_comb begin
		flags_word = 16'h0000;
		flags_word[`DMR_F_READY] = drive_ready;
		flags_word[`DMR_F_MOTOR +: 2] = motor_select;
		flags_word[`DMR_F_SYNC] = sync_machine;
		flags_word[`DMR_F_OVL] = overload_alarm;
		flags_word[`DMR_F_SRC +: 2] = cmd_source;
		flags_word[`DMR_F_TORQUE] = torque_mode;
		flags_word[`DMR_F_POS] = position_mode;
		flags_word[`DMR_F_METHOD +: 2] = control_method;
	end

	always_comb begin
		if (dc_link_volts > `DMR_VBUS_MAX) begin
			vbus_clamped = `DMR_VBUS_MAX;
		end else begin
			vbus_clamped = dc_link_volts;
		end
	end

	always_comb begin
		step_clamped = {12'h000, speed_step};
		if (step_clamped > `DMR_STEP_MAX) begin
			step_clamped = `DMR_STEP_MAX;
		end
	end

	// read decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = 16'h0000;
		case (req_addr)
			`DMR_A_AO2:       rd_data = ao_two_setpoint_ff;
			`DMR_A_STATE:     rd_data = {13'h0000, run_state};
			`DMR_A_FLAGS:     rd_data = flags_word;
			`DMR_A_FAULT:     rd_data = fault_number;
			`DMR_A_FREQ_ACT:  rd_data = freq_actual;
			`DMR_A_FREQ_SET:  rd_data = freq_target;
			`DMR_A_VBUS:      rd_data = vbus_clamped;
			`DMR_A_VOUT:      rd_data = motor_volts;
			`DMR_A_IOUT:      rd_data = motor_amps;
			`DMR_A_SPEED:     rd_data = shaft_rpm;
			`DMR_A_POWER:     rd_data = power_pct;
			`DMR_A_TORQUE:    rd_data = torque_pct;
			`DMR_A_LOOP_REF:  rd_data = loop_ref_pct;
			`DMR_A_LOOP_FB:   rd_data = loop_meas_pct;
			`DMR_A_IN_MASK:   rd_data = {10'h000, term_state_ff};
			`DMR_A_OUT_MASK:  rd_data = {12'h000, output_terminal_state};
			`DMR_A_AIN1:      rd_data = ain_one;
			`DMR_A_AIN2:      rd_data = ain_two;
			`DMR_A_AIN3:      rd_data = ain_three;
			`DMR_A_AIN4:      rd_data = ain_four;
			`DMR_A_PULSE1:    rd_data = pulse_a_rate;
			`DMR_A_PULSE2:    rd_data = pulse_b_rate;
			`DMR_A_STEP:      rd_data = step_clamped;
			`DMR_A_LENGTH:    rd_data = length_count;
			`DMR_A_COUNT:     rd_data = event_count;
			`DMR_A_TQ_REF:    rd_data = torque_ref_pct;
			`DMR_A_IDENT:     rd_data = IDENT_CODE;
			`DMR_A_FAULT_REC: rd_data = fault_history;
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// write decode
	always_comb begin
		wr_ok       = (req_addr == `DMR_A_AO2);
		wr_range_ok = ($signed(req_wdata) <= AO_MAX) && ($signed(req_wdata) >= AO_MIN);
	end

	always_comb begin
		is_read  = (req_func == `DMR_FC_READ);
		is_write = (req_func == `DMR_FC_WRITE);
	end

	// response selection
	always_comb begin
		nxt_exc  = 1'b0;
		nxt_code = 8'h00;
		nxt_data = 16'h0000;
		if (is_read) begin
			if (rd_hit) begin
				nxt_data = rd_data;
			end else begin
				nxt_exc  = 1'b1;
				nxt_code = `DMR_EC_ADDR;
			end
		end else if (is_write) begin
			if (wr_ok && wr_range_ok) begin
				// single-register write echoes the data
				nxt_data = req_wdata;
			end else if (wr_ok) begin
				nxt_exc  = 1'b1;
				nxt_code = `DMR_EC_VALUE;
			end else if (rd_hit) begin
				nxt_exc  = 1'b1;
				nxt_code = `DMR_EC_RO;
			end else begin
				nxt_exc  = 1'b1;
				nxt_code = `DMR_EC_ADDR;
			end
		end else begin
			nxt_exc  = 1'b1;
			nxt_code = `DMR_EC_FUNC;
		end
	end

	// response valid, one cycle per request
	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_valid_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= req_valid;
		end
	end

	// echoed function code, top bit marks an exception
	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_func_ff <= 8'h00;
		end else if (req_valid) begin
			rsp_func_ff <= nxt_exc ? (req_func | `DMR_FC_EXC) : req_func;
		end
	end

	// response data, held until the next answer
	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_data_ff <= 16'h0000;
		end else if (req_valid) begin
			rsp_data_ff <= nxt_data;
		end
	end

	// exception flag and code
	always_ff @(posedge mclk) begin
		if (reset) begin
			rsp_exc_ff  <= 1'b0;
			rsp_code_ff <= 8'h00;
		end else if (req_valid) begin
			rsp_exc_ff  <= nxt_exc;
			rsp_code_ff <= nxt_code;
		end
	end

	always_comb begin
		if (req_valid && is_write && wr_ok && wr_range_ok) begin
			nxt_ao_setpoint = req_wdata;
		end else begin
			nxt_ao_setpoint = ao_two_setpoint_ff;
		end
	end

	// stored setpoint register
	always_ff @(posedge mclk) begin
		if (reset) begin
			ao_two_setpoint_ff <= `DMR_AO2_RST;
		end else begin
			ao_two_setpoint_ff <= nxt_ao_setpoint;
		end
	end

	// applied only under comm source, scaled down
	always_comb begin
		if (ao_two_src_comm) begin
			nxt_ao_pct = 8'(ao_two_setpoint_ff / AO_DIV);
		end else begin
			nxt_ao_pct = 8'h00;
		end
	end

	// applied setting register
	always_ff @(posedge mclk) begin
		if (reset) begin
			ao_two_pct_ff <= 8'h00;
		end else begin
			ao_two_pct_ff <= nxt_ao_pct;
		end
	end

endmodule
`default_nettype wire

// ### dmr_register_map_checker.sv
// dmr_register_map_checker.sv: port assertions of the register bank
// assumes: single mclk domain, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module dmr_register_map_checker (
	// clock and reset
	input wire logic                  mclk,
	input wire logic                  reset,
	// register request
	input wire logic                  req_valid,
	input wire logic [7:0]            req_func,
	input wire logic [15:0]           req_addr,
	input wire logic [15:0]           req_wdata,
	// register response
	input wire logic                  rsp_valid_ff,
	input wire logic                  rsp_exc_ff,
	input wire logic [7:0]            rsp_func_ff,
	input wire logic [7:0]            rsp_code_ff,
	input wire logic [15:0]           rsp_data_ff,
	// drive state and monitored values
	input wire logic [15:0]           dc_link_volts,
	input wire logic [15:0]           shaft_rpm,
	input wire logic                  drive_ready,
	input wire logic                  sync_machine,
	input wire logic                  overload_alarm,
	input wire dmr_pkg::dmr_cmd_src_t cmd_source,
	input wire logic                  torque_mode,
	input wire logic                  position_mode,
	input wire logic [1:0]            motor_select,
	input wire logic [1:0]            control_method,
	input wire logic [3:0]            output_terminal_state,
	// analog output two
	input wire logic                  ao_two_src_comm,
	input wire logic signed [15:0]    ao_two_setpoint_ff,
	input wire logic signed [7:0]     ao_two_pct_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic [15:0] flags_exp, vbus_exp;
	logic        rd, wr, ao_wr;
	assign flags_exp = {4'h0, control_method, position_mode, torque_mode, 1'b0, cmd_source,
		overload_alarm, sync_machine, motor_select, drive_ready};
	assign vbus_exp = (dc_link_volts > 16'h4E20) ? 16'h4E20 : dc_link_volts;
	assign rd = req_valid && req_func == 8'h03;
	assign wr = req_valid && req_func == 8'h06;
	assign ao_wr = wr && req_addr == 16'h200E;
	a_flags_read: assert property (
		rd && req_addr == 16'h2101 |=> rsp_data_ff == $past(flags_exp) && !rsp_exc_ff)
		else $error("flags word read wrong");
	a_vbus_clamp: assert property (
		rd && req_addr == 16'h3002 |=> rsp_data_ff == $past(vbus_exp))
		else $error("bus voltage read wrong");
	a_speed_read: assert property (
		rd && req_addr == 16'h3005 |=> rsp_data_ff == $past(shaft_rpm))
		else $error("speed read wrong");
	a_out_mask: assert property (
		rd && req_addr == 16'h300B |=> rsp_data_ff == {12'h000, $past(output_terminal_state)})
		else $error("output mask read wrong");
	a_ro_reject: assert property (
		wr && req_addr >= 16'h3000 && req_addr <= 16'h3016
		|=> rsp_exc_ff && rsp_code_ff == 8'h07 && rsp_func_ff == 8'h86)
		else $error("read-only write not refused");
	a_ao_accept: assert property (
		ao_wr && $signed(req_wdata) >= -1000 && $signed(req_wdata) <= 1000
		|=> ao_two_setpoint_ff == $past(req_wdata) && !rsp_exc_ff)
		else $error("setpoint write not stored");
	a_ao_refuse: assert property (
		ao_wr && ($signed(req_wdata) > 1000 || $signed(req_wdata) < -1000)
		|=> rsp_code_ff == 8'h04 && $stable(ao_two_setpoint_ff))
		else $error("out of range setpoint accepted");
	a_ao_gated: assert property (
		!ao_two_src_comm |=> ao_two_pct_ff == 8'h00)
		else $error("applied output not gated");
	a_ao_scale: assert property (
		ao_two_src_comm |=> ao_two_pct_ff == 8'($past(ao_two_setpoint_ff) / 10))
		else $error("applied output scaling wrong");
endmodule
bind dmr_register_map dmr_register_map_checker i_dmr_register_map_checker (.mclk, .reset,
	.req_valid, .req_func, .req_addr, .req_wdata, .rsp_valid_ff, .rsp_exc_ff, .rsp_func_ff,
	.rsp_code_ff, .rsp_data_ff, .dc_link_volts, .shaft_rpm, .drive_ready, .sync_machine,
	.overload_alarm, .cmd_source, .torque_mode, .position_mode, .ao_two_src_comm,
	.motor_select, .control_method, .output_terminal_state, .ao_two_setpoint_ff, .ao_two_pct_ff);
`default_nettype wire

// ### drive_monitor_register_map_tb.sv
// drive_monitor_register_map_tb.sv: register sequences against the drive monitor bank
// assumes: master model drives requests, bench drives drive-side levels
`timescale 1ns/100ps
`default_nettype none
module drive_monitor_register_map_tb;
	logic                    mclk, reset, req_valid, rsp_valid_ff, rsp_exc_ff;
	logic [7:0]              req_func, rsp_func_ff, rsp_code_ff;
	logic [15:0]             req_addr, req_wdata, rsp_data_ff;
	dmr_pkg::dmr_run_state_t run_state;
	dmr_pkg::dmr_cmd_src_t   cmd_source;
	logic                    drive_ready, sync_machine, overload_alarm, torque_mode;
	logic                    position_mode, ao_two_src_comm;
	logic [1:0]              motor_select, control_method;
	logic [15:0]             mon [0:24];
	logic [3:0]              speed_step, out_state;
	logic [5:0]              pins;
	logic signed [15:0]      ao_sp;
	logic signed [7:0]       ao_pct;
	logic [15:0]             ro_list [6] = '{16'h2100, 16'h2101, 16'h3002, 16'h3005, 16'h300A,
		16'h5000};
	logic [15:0]             ao_val [5] = '{16'hFC18, 16'hFFF1, 16'h03E8, 16'h03E9, 16'hFC17};
	logic [15:0]             ao_exp [5] = '{16'hFF9C, 16'hFFFF, 16'h0064, 16'h0064, 16'h0064};
	int                      fail_count, comparisons;
	dmr_master_model i_dmr_master_model (.mclk(mclk), .req_valid(req_valid), .req_func(req_func),
		.req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid_ff(rsp_valid_ff));
	// identity value is arbitrary
	dmr_register_map #(.IDENT_CODE(16'h1234)) i_dmr_register_map (.mclk(mclk), .reset(reset),
		.req_valid(req_valid), .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
		.rsp_valid_ff(rsp_valid_ff), .rsp_func_ff(rsp_func_ff), .rsp_data_ff(rsp_data_ff),
		.rsp_exc_ff(rsp_exc_ff), .rsp_code_ff(rsp_code_ff), .run_state(run_state),
		.drive_ready(drive_ready), .motor_select(motor_select), .sync_machine(sync_machine),
		.overload_alarm(overload_alarm), .cmd_source(cmd_source), .torque_mode(torque_mode),
		.position_mode(position_mode), .control_method(control_method),
		.fault_number(mon[23]), .fault_history(mon[24]), .freq_actual(mon[0]),
		.freq_target(mon[1]), .dc_link_volts(mon[2]), .motor_volts(mon[3]), .motor_amps(mon[4]),
		.shaft_rpm(mon[5]), .power_pct(mon[6]), .torque_pct(mon[7]), .loop_ref_pct(mon[8]),
		.loop_meas_pct(mon[9]), .ain_one(mon[12]), .ain_two(mon[13]), .ain_three(mon[14]),
		.ain_four(mon[15]), .pulse_a_rate(mon[16]), .pulse_b_rate(mon[17]),
		.speed_step(speed_step), .length_count(mon[19]), .event_count(mon[20]),
		.torque_ref_pct(mon[21]), .input_terminal_pins(pins), .output_terminal_state(out_state),
		.ao_two_src_comm(ao_two_src_comm), .ao_two_setpoint_ff(ao_sp), .ao_two_pct_ff(ao_pct));
	task automatic chk(input string what, input logic [15:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic op(input logic [7:0] f, input logic [15:0] a, d, exp, input logic [7:0] code);
		logic ok;
		i_dmr_master_model.xfer(f, a, d, ok);
		chk("response valid", 16'h0001, {15'h0000, ok});
		chk("response function", {8'h00, f | ((code != 8'h00) ? 8'h80 : 8'h00)}, {8'h00, rsp_func_ff});
		chk("response code", {7'h00, code != 8'h00, code}, {7'h00, rsp_exc_ff, rsp_code_ff});
		chk("response data", exp, rsp_data_ff);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic logic [15:0] mon_exp(input int i);
		case (i)
			2: mon_exp = 16'h4E20;
			10: mon_exp = {10'h000, pins};
			11: mon_exp = {12'h000, out_state};
			18: mon_exp = {12'h000, speed_step};
			22: mon_exp = 16'h1234;
			default: mon_exp = mon[i];
		endcase
	endfunction
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		reset = 1'b1;
		run_state = dmr_pkg::DMR_STOPPED;
		cmd_source = dmr_pkg::DMR_SRC_KEYPAD;
		{drive_ready, sync_machine, overload_alarm, torque_mode, position_mode} = 5'h00;
		{ao_two_src_comm, motor_select, control_method} = 5'h00;
		// signed monitors carry negative two's complement values, bus voltage above clamp
		foreach (mon[i]) mon[i] = 16'h8001 + 16'(i * 291);
		speed_step = 4'hB;
		out_state = 4'h9;
		pins = 6'h2D;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1 chk("setpoint after reset", 16'h0000, ao_sp);
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			drive_ready <= k[0];
			motor_select <= 2'(k);
			sync_machine <= k[1];
			overload_alarm <= ~k[0];
			cmd_source <= dmr_pkg::dmr_cmd_src_t'(k % 3);
			torque_mode <= k[0];
			position_mode <= ~k[1];
			control_method <= 2'(3 - k);
			op(8'h03, 16'h2101, 16'h0000, {4'h0, 2'(3 - k), ~k[1], k[0], 1'b0, 2'(k % 3), ~k[0],
				k[1], 2'(k), k[0]}, 8'h00);
		end
		for (int j = 1; j < 7; j++) begin
			@(posedge mclk);
			run_state <= dmr_pkg::dmr_run_state_t'(j);
			op(8'h03, 16'h2100, 16'h0000, 16'(j), 8'h00);
		end
		for (int i = 0; i < 23; i++) begin
			op(8'h03, 16'h3000 + 16'(i), 16'h0000, mon_exp(i), 8'h00);
		end
		op(8'h03, 16'h2102, 16'h0000, mon[23], 8'h00);
		op(8'h03, 16'h5000, 16'h0000, mon[24], 8'h00);
		// pin change shows only after the synchroniser agrees
		@(posedge mclk);
		pins <= 6'h12;
		mon[2] <= 16'h4E1F;
		op(8'h03, 16'h300A, 16'h0000, 16'h002D, 8'h00);
		repeat (3) @(posedge mclk);
		op(8'h03, 16'h300A, 16'h0000, 16'h0012, 8'h00);
		op(8'h03, 16'h3002, 16'h0000, 16'h4E1F, 8'h00);
		// one-cycle pin pulse must be filtered
		@(posedge mclk);
		pins <= 6'h3F;
		@(posedge mclk);
		pins <= 6'h12;
		repeat (2) @(posedge mclk);
		op(8'h03, 16'h300A, 16'h0000, 16'h0012, 8'h00);
		for (int i = 0; i < 6; i++) begin
			op(8'h06, ro_list[i], 16'h0055, 16'h0000, 8'h07);
		end
		op(8'h03, 16'h3017, 16'h0000, 16'h0000, 8'h02);
		op(8'h06, 16'h4000, 16'h0055, 16'h0000, 8'h02);
		op(8'h04, 16'h2101, 16'h0000, 16'h0000, 8'h01);
		op(8'h06, 16'h200E, 16'h01F4, 16'h01F4, 8'h00);
		repeat (2) @(posedge mclk);
		#1 chk("applied output", 16'h0000, 16'(ao_pct));
		@(posedge mclk);
		ao_two_src_comm <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk("applied output", 16'h0032, 16'(ao_pct));
		for (int i = 0; i < 5; i++) begin
			op(8'h06, 16'h200E, ao_val[i], (i < 3) ? ao_val[i] : 16'h0000,
				(i < 3) ? 8'h00 : 8'h04);
			repeat (2) @(posedge mclk);
			#1 chk("applied output", ao_exp[i], 16'(ao_pct));
		end
		op(8'h03, 16'h200E, 16'h0000, 16'h03E8, 8'h00);
		@(posedge mclk);
		ao_two_src_comm <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk("applied output", 16'h0000, 16'(ao_pct));
		// reset in mid-run clears the stored setpoint
		@(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		#1 chk("setpoint after reset", 16'h0000, ao_sp);
		op(8'h03, 16'h200E, 16'h0000, 16'h0000, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
